// ---- rtl/ccsr_regs.v ----
// Charger configuration and status register set with its timing and alert logic
`timescale 1ns/1ps
`include "ccsr_defs.vh"

module ccsr_regs #(
  parameter TW = 24,
  parameter [TW-1:0] T_LONG_CYC = `CCSR_T_LONG_US * `CCSR_CLK_MHZ,
  parameter [TW-1:0] T_SHORT_CYC = `CCSR_T_SHORT_US * `CCSR_CLK_MHZ
) (
  input wire clk,
  input wire rstn,
  input wire bias_ok,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] cmd,
  input wire [15:0] wr_data,
  output reg [15:0] rd_data,
  output reg rd_valid,
  input wire adapter_present,
  input wire otg_request,
  input wire system_power_monitor_enabled,
  input wire battery_only,
  input wire [3:0] config_strap_pin,
  input wire trickle_active,
  input wire [1:0] conv_mode,
  input wire [2:0] charger_state,
  input wire [1:0] active_loop,
  input wire reference_active,
  input wire adapter_current_trip,
  input wire battery_discharge_trip,
  input wire low_system_voltage_trip,
  input wire comparator_input,
  output reg [1:0] trickle_sel,
  output reg two_level_limit_en,
  output reg otg_enable,
  output reg input_switch_gate,
  output reg hot_alert_n,
  output reg comparator_en,
  output reg comparator_ref_2v,
  output reg comparator_output,
  output reg gross_overcurrent_protect,
  output reg system_power_monitor_low_gain,
  output reg [5:0] otg_voltage_code,
  output reg [5:0] otg_current_code
);
  // Microseconds to clock cycles, cut on purpose to the timer width
  function [TW-1:0] us_cycles;
    input [31:0] us;
    reg [31:0] full;
    begin
      full = us * `CCSR_CLK_MHZ;
      us_cycles = full[TW-1:0];
    end
  endfunction

  localparam [TW-1:0] C10US = us_cycles(`CCSR_T_10US);
  localparam [TW-1:0] C100US = us_cycles(`CCSR_T_100US);
  localparam [TW-1:0] C500US = us_cycles(`CCSR_T_500US);
  localparam [TW-1:0] C1MS = us_cycles(`CCSR_T_1MS);
  localparam [TW-1:0] C5MS = us_cycles(`CCSR_T_5MS);
  localparam [TW-1:0] C10MS = us_cycles(`CCSR_T_10MS);
  localparam [TW-1:0] C15MS = us_cycles(`CCSR_T_15MS);
  localparam [TW-1:0] C20MS = us_cycles(`CCSR_T_20MS);

  localparam [2:0] SW_OFF = 3'b001;
  localparam [2:0] SW_WAIT = 3'b010;
  localparam [2:0] SW_ON = 3'b100;

  // ****************************************
  // Helper functions
  // ****************************************
  function [5:0] clamp_code;
    input [5:0] v;
    input [5:0] lo;
    input [5:0] hi;
    begin
      if (v > hi) begin
        clamp_code = hi;
      end else if (v < lo) begin
        clamp_code = lo;
      end else begin
        clamp_code = v;
      end
    end
  endfunction

  function [TW-1:0] hot_db_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: hot_db_cycles = C10US;
        2'b01: hot_db_cycles = C100US;
        2'b10: hot_db_cycles = C500US;
        default: hot_db_cycles = C1MS;
      endcase
    end
  endfunction

  function [TW-1:0] hot_dur_cycles;
    input [2:0] sel;
    begin
      case (sel)
        3'b000: hot_dur_cycles = C10MS;
        3'b001: hot_dur_cycles = C20MS;
        3'b010: hot_dur_cycles = C15MS;
        3'b011: hot_dur_cycles = C5MS;
        3'b100: hot_dur_cycles = C1MS;
        3'b101: hot_dur_cycles = C500US;
        3'b110: hot_dur_cycles = C100US;
        default: hot_dur_cycles = {TW{1'b0}};
      endcase
    end
  endfunction

  // ****************************************
  // Control registers
  // ****************************************
  reg [15:0] ctrl2;
  reg [5:0] otgv;
  reg [5:0] otgi;
  reg [3:0] strap_code;
  reg strap_valid;
  reg adapter_current_hot;
  reg battery_discharge_hot;
  reg low_voltage_hot;
  wire acc_ok = bias_ok;

  always @(posedge clk) begin
    if (!rstn) begin
      ctrl2 <= `CCSR_CTRL2_RST;
      otgv <= `CCSR_OTGV_RST;
      otgi <= `CCSR_OTGI_RST;
    end else if (wr_en && acc_ok) begin
      case (cmd)
        `CCSR_CMD_CTRL2: begin
          ctrl2 <= wr_data;
        end
        `CCSR_CMD_OTGV: begin
          otgv <= clamp_code(wr_data[`CCSR_VAL_HI:`CCSR_VAL_LO], `CCSR_OTGV_MIN, `CCSR_OTGV_MAX);
        end
        `CCSR_CMD_OTGI: begin
          otgi <= clamp_code(wr_data[`CCSR_VAL_HI:`CCSR_VAL_LO], 6'h00, `CCSR_OTGI_MAX);
        end
        default: begin
          ctrl2 <= ctrl2;
        end
      endcase
    end
  end

  // Strap is latched whenever battery_only is low or the monitor is on
  always @(posedge clk) begin
    if (!rstn) begin
      strap_code <= 4'h0;
      strap_valid <= 1'b0;
    end else if (!battery_only || system_power_monitor_enabled) begin
      strap_code <= config_strap_pin;
      strap_valid <= 1'b1;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  wire [15:0] info_word = {reference_active, active_loop, adapter_current_hot, battery_discharge_hot,
    low_voltage_hot, charger_state, conv_mode, trickle_active, strap_valid ? strap_code : 4'h0};
  reg [15:0] next_rd_data;

  always @* begin
    case (cmd)
      `CCSR_CMD_INFO: next_rd_data = info_word;
      `CCSR_CMD_CTRL2: next_rd_data = ctrl2;
      `CCSR_CMD_OTGV: next_rd_data = {3'b000, otgv, 7'b000_0000};
      `CCSR_CMD_OTGI: next_rd_data = {3'b000, otgi, 7'b000_0000};
      default: next_rd_data = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en && acc_ok;
      if (rd_en && acc_ok) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // ****************************************
  // Registered option outputs and comparator output
  // ****************************************
  always @(posedge clk) begin
    if (!rstn) begin
      trickle_sel <= 2'b00;
      two_level_limit_en <= 1'b0;
      comparator_en <= 1'b1;
      comparator_ref_2v <= 1'b0;
      comparator_output <= 1'b0;
      gross_overcurrent_protect <= 1'b1;
      system_power_monitor_low_gain <= 1'b0;
      otg_voltage_code <= `CCSR_OTGV_RST;
      otg_current_code <= `CCSR_OTGI_RST;
    end else begin
      trickle_sel <= ctrl2[`CCSR_TRK_HI:`CCSR_TRK_LO];
      two_level_limit_en <= ctrl2[`CCSR_TWO_LVL];
      comparator_en <= !ctrl2[`CCSR_CMP_DIS];
      comparator_ref_2v <= ctrl2[`CCSR_CMP_REF];
      // Disabled comparator parks low so downstream sees no stale trip
      comparator_output <= !ctrl2[`CCSR_CMP_DIS] && (comparator_input ^ ctrl2[`CCSR_CMP_POL]);
      gross_overcurrent_protect <= !ctrl2[`CCSR_OCP_DIS];
      system_power_monitor_low_gain <= ctrl2[`CCSR_PMON_GAIN];
      otg_voltage_code <= otgv;
      otg_current_code <= otgi;
    end
  end

  // ****************************************
  // OTG enable debounce
  // ****************************************
  wire otg_done;
  ccsr_timer #(.W(TW)) u_otg_tmr (
    .clk(clk),
    .rstn(rstn),
    .load(1'b0),
    .count(ctrl2[`CCSR_OTG_DB] ? T_SHORT_CYC : T_LONG_CYC),
    .run(otg_request),
    .done(otg_done)
  );

  always @(posedge clk) begin
    if (!rstn) begin
      otg_enable <= 1'b0;
    end else begin
      otg_enable <= otg_request && otg_done;
    end
  end

  // ****************************************
  // Input switch gate sequencing
  // ****************************************
  reg [2:0] sw_state;
  reg [2:0] next_sw_state;
  reg first_done;
  wire sw_done;
  // Until the gate has dropped once, the short delay is forced
  wire [TW-1:0] sw_delay = (first_done && !ctrl2[`CCSR_SW_DB]) ? T_LONG_CYC : T_SHORT_CYC;

  ccsr_timer #(.W(TW)) u_sw_tmr (
    .clk(clk),
    .rstn(rstn),
    .load(1'b0),
    .count(sw_delay),
    .run(sw_state == SW_WAIT),
    .done(sw_done)
  );

  always @* begin
    case (sw_state)
      SW_OFF: next_sw_state = adapter_present ? SW_WAIT : SW_OFF;
      SW_WAIT: next_sw_state = !adapter_present ? SW_OFF : (sw_done ? SW_ON : SW_WAIT);
      SW_ON: next_sw_state = adapter_present ? SW_ON : SW_OFF;
      default: next_sw_state = SW_OFF;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      sw_state <= SW_OFF;
      first_done <= 1'b0;
      input_switch_gate <= 1'b0;
    end else begin
      sw_state <= next_sw_state;
      if (sw_state == SW_ON && next_sw_state == SW_OFF) begin
        first_done <= 1'b1;
      end
      if (otg_enable) begin
        input_switch_gate <= !ctrl2[`CCSR_SW_OTG];
      end else begin
        input_switch_gate <= (next_sw_state == SW_ON);
      end
    end
  end

  // ****************************************
  // Hot alert debounce and minimum hold
  // ****************************************
  wire ac_done;
  wire dc_done;
  wire lv_done;
  reg [TW-1:0] hold_left;

  ccsr_timer #(.W(TW)) u_ac_tmr (
    .clk(clk),
    .rstn(rstn),
    .load(1'b0),
    .count(hot_db_cycles(ctrl2[`CCSR_HOT_DB_HI:`CCSR_HOT_DB_LO])),
    .run(adapter_current_trip),
    .done(ac_done)
  );

  ccsr_timer #(.W(TW)) u_dc_tmr (
    .clk(clk),
    .rstn(rstn),
    .load(1'b0),
    .count(hot_db_cycles(ctrl2[`CCSR_HOT_DB_HI:`CCSR_HOT_DB_LO])),
    .run(battery_discharge_trip),
    .done(dc_done)
  );

  ccsr_timer #(.W(TW)) u_lv_tmr (
    .clk(clk),
    .rstn(rstn),
    .load(1'b0),
    .count(C10US),
    .run(low_system_voltage_trip),
    .done(lv_done)
  );

  wire any_hot = adapter_current_hot || battery_discharge_hot || low_voltage_hot;

  always @(posedge clk) begin
    if (!rstn) begin
      adapter_current_hot <= 1'b0;
      battery_discharge_hot <= 1'b0;
      low_voltage_hot <= 1'b0;
      hold_left <= {TW{1'b0}};
      hot_alert_n <= 1'b1;
    end else begin
      adapter_current_hot <= adapter_current_trip && ac_done;
      battery_discharge_hot <= battery_discharge_trip && dc_done;
      low_voltage_hot <= low_system_voltage_trip && lv_done;
      // Hold is armed on each assertion cycle so the pin stays low for the minimum after release
      if (any_hot) begin
        hold_left <= hot_dur_cycles(ctrl2[`CCSR_HOT_DUR_HI:`CCSR_HOT_DUR_LO]);
      end else if (hold_left != {TW{1'b0}}) begin
        hold_left <= hold_left - {{(TW-1){1'b0}}, 1'b1};
      end
      hot_alert_n <= !(any_hot || (hold_left > {{(TW-1){1'b0}}, 1'b1}));
    end
  end
endmodule

// ---- inc/ccsr_defs.vh ----
// Register offsets, field positions, reset values and times in microseconds for the charger register set
`ifndef CCSR_DEFS_VH
`define CCSR_DEFS_VH

// ****************************************
// Register command codes
// ****************************************
`define CCSR_CMD_INFO 8'h3A
`define CCSR_CMD_CTRL2 8'h3D
`define CCSR_CMD_OTGV 8'h49
`define CCSR_CMD_OTGI 8'h4A

// ****************************************
// Reset values
// ****************************************
`define CCSR_CTRL2_RST 16'h0000
`define CCSR_OTGV_RST 6'h26
`define CCSR_OTGI_RST 6'h00

// ****************************************
// Control word field positions
// ****************************************
`define CCSR_TRK_HI 15
`define CCSR_TRK_LO 14
`define CCSR_OTG_DB 13
`define CCSR_TWO_LVL 12
`define CCSR_SW_DB 11
`define CCSR_HOT_DB_HI 10
`define CCSR_HOT_DB_LO 9
`define CCSR_HOT_DUR_HI 8
`define CCSR_HOT_DUR_LO 6
`define CCSR_SW_OTG 5
`define CCSR_CMP_REF 4
`define CCSR_CMP_DIS 3
`define CCSR_CMP_POL 2
`define CCSR_OCP_DIS 1
`define CCSR_PMON_GAIN 0

// ****************************************
// Value field of the reverse output registers
// ****************************************
`define CCSR_VAL_HI 12
`define CCSR_VAL_LO 7
`define CCSR_OTGV_MAX 6'h2A
`define CCSR_OTGV_MIN 6'h26
`define CCSR_OTGI_MAX 6'h20

// ****************************************
// Times in microseconds and clock rate
// ****************************************
`define CCSR_CLK_MHZ 10
`define CCSR_T_LONG_US 1300000
`define CCSR_T_SHORT_US 150000
`define CCSR_T_10US 10
`define CCSR_T_100US 100
`define CCSR_T_500US 500
`define CCSR_T_1MS 1000
`define CCSR_T_5MS 5000
`define CCSR_T_10MS 10000
`define CCSR_T_15MS 15000
`define CCSR_T_20MS 20000

`endif

// ---- rtl/ccsr_timer.v ----
// Down counter that raises done after a loaded cycle count
`timescale 1ns/1ps
module ccsr_timer #(
  parameter W = 24
) (
  input wire clk,
  input wire rstn,
  input wire load,
  input wire [W-1:0] count,
  input wire run,
  output reg done
);
  reg [W-1:0] left;

  // Load restarts the wait; dropping run aborts it
  always @(posedge clk) begin
    if (!rstn) begin
      left <= {W{1'b0}};
      done <= 1'b0;
    end else if (load || !run) begin
      left <= count;
      done <= 1'b0;
    end else if (left != {W{1'b0}}) begin
      left <= left - {{(W-1){1'b0}}, 1'b1};
      done <= (left == {{(W-1){1'b0}}, 1'b1});
    end else begin
      done <= 1'b1;
    end
  end
endmodule

// ---- verif/ccsr_checker.sv ----
// Port checks for the charger register set
`timescale 1ns/1ps
module ccsr_checker (
  input wire clk,
  input wire rstn,
  input wire bias_ok,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] cmd,
  input wire [15:0] wr_data,
  input wire rd_valid,
  input wire otg_request,
  input wire otg_enable,
  input wire [1:0] trickle_sel,
  input wire two_level_limit_en,
  input wire gross_overcurrent_protect,
  input wire system_power_monitor_low_gain,
  input wire [5:0] otg_voltage_code,
  input wire [5:0] otg_current_code
);
  wire ctl_wr = wr_en && bias_ok && cmd == 8'h3D;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_ans; rd_en && bias_ok |=> rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_quiet; !(rd_en && bias_ok) |=> !rd_valid; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("answer without accepted read");
  property p_trk; ctl_wr |-> ##2 trickle_sel == $past(wr_data[15:14], 2); endproperty
  a_trk: assert property (p_trk) else $error("trickle select wrong");
  property p_two; ctl_wr |-> ##2 two_level_limit_en == $past(wr_data[12], 2); endproperty
  a_two: assert property (p_two) else $error("two level limit wrong");
  property p_ocp; ctl_wr |-> ##2 gross_overcurrent_protect == !$past(wr_data[1], 2); endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent enable wrong");
  property p_gain; ctl_wr |-> ##2 system_power_monitor_low_gain == $past(wr_data[0], 2); endproperty
  a_gain: assert property (p_gain) else $error("monitor gain wrong");
  property p_vrange; otg_voltage_code >= 6'h26 && otg_voltage_code <= 6'h2A; endproperty
  a_vrange: assert property (p_vrange) else $error("voltage code out of range");
  // Any code with the top bit set is at or above the ceiling
  property p_iclamp;
    wr_en && bias_ok && cmd == 8'h4A |-> ##2
      otg_current_code == ($past(wr_data[12], 2) ? 6'h20 : $past(wr_data[12:7], 2));
  endproperty
  a_iclamp: assert property (p_iclamp) else $error("current code wrong");
  property p_otg_drop; !otg_request |=> !otg_enable; endproperty
  a_otg_drop: assert property (p_otg_drop) else $error("reverse output on without request");
endmodule

// ---- verif/ccsr_host.sv ----
// Host model issuing register reads and writes
`timescale 1ns/1ps
module ccsr_host (
  input wire clk,
  input wire rd_valid,
  input wire [15:0] rd_data,
  output reg wr_en,
  output reg rd_en,
  output reg [7:0] cmd,
  output reg [15:0] wr_data
);
  integer seed = 81;
  initial begin
    wr_en = 0;
    rd_en = 0;
    cmd = 0;
    wr_data = 0;
  end
  // Idle lines scramble so a stale command never looks valid
  task wr(input [7:0] c, input [15:0] x);
    cmd = c;
    wr_data = x;
    wr_en = 1;
    @(posedge clk);
    #1;
    wr_en = 0;
    cmd = $random(seed);
    wr_data = $random(seed);
    @(posedge clk);
    #1;
  endtask
  task rd(input [7:0] c, output [15:0] x, output v);
    cmd = c;
    rd_en = 1;
    @(posedge clk);
    #1;
    rd_en = 0;
    cmd = $random(seed);
    v = rd_valid;
    x = rd_data;
    @(posedge clk);
    #1;
  endtask
endmodule

// ---- verif/ccsr_regs_tb.sv ----
// Self-checking bench for the charger register set
`timescale 1ns/1ps
module ccsr_regs_tb;
  localparam int TL = 40;
  localparam int TS = 20;
  reg clk = 0, rstn = 0, bias_ok = 1, adapter_present = 0, otg_request = 0, system_power_monitor_enabled = 0, battery_only = 1;
  reg [3:0] config_strap_pin = 4'h5;
  reg trickle_active = 0, reference_active = 0, adapter_current_trip = 0, battery_discharge_trip = 0;
  reg low_system_voltage_trip = 0, comparator_input = 0;
  reg [1:0] conv_mode = 0, active_loop = 0;
  reg [2:0] charger_state = 0;
  wire wr_en, rd_en, rd_valid, two_level_limit_en, otg_enable, input_switch_gate, hot_alert_n;
  wire comparator_en, comparator_ref_2v, comparator_output, gross_overcurrent_protect, system_power_monitor_low_gain;
  wire [7:0] cmd;
  wire [15:0] wr_data, rd_data;
  wire [1:0] trickle_sel;
  wire [5:0] otg_voltage_code, otg_current_code;
  int err_count = 0, n_compared = 0, ctrl = 0, n, i, x, e;
  int vv[6] = '{'hFFFF, 0, 'h1380, 'h1500, 'h0F80, 'hE07F};
  logic [15:0] d;
  logic v;
  always #50 clk = ~clk;
  // Long counts shortened so the gate and reverse output delays fit the run
  ccsr_regs #(.T_LONG_CYC(24'h00_0028), .T_SHORT_CYC(24'h00_0014)) dut (.clk, .rstn, .bias_ok, .wr_en, .rd_en,
    .cmd, .wr_data, .rd_data, .rd_valid, .adapter_present, .otg_request, .system_power_monitor_enabled, .battery_only,
    .config_strap_pin, .trickle_active, .conv_mode, .charger_state, .active_loop, .reference_active,
    .adapter_current_trip, .battery_discharge_trip, .low_system_voltage_trip, .comparator_input, .trickle_sel,
    .two_level_limit_en, .otg_enable, .input_switch_gate, .hot_alert_n, .comparator_en, .comparator_ref_2v,
    .comparator_output, .gross_overcurrent_protect, .system_power_monitor_low_gain, .otg_voltage_code,
    .otg_current_code);
  ccsr_host h (.clk, .rd_valid, .rd_data, .wr_en, .rd_en, .cmd, .wr_data);
  task chk(input logic [15:0] s, input logic [15:0] x);
    n_compared++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task give_verdict;
    $display("mismatches=%0d compared=%0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task rchk(input [7:0] c, input [15:0] x);
    h.rd(c, d, v);
    chk(v, 1'h1);
    chk(d, x);
  endtask
  function logic sig(int w);
    case (w)
      0: sig = otg_enable;
      1: sig = input_switch_gate;
      default: sig = !hot_alert_n;
    endcase
  endfunction
  // Bounded wait so a stuck output ends as a mismatch, not a hang
  task meas(int w, logic lv, int lo);
    n = 0;
    while (sig(w) !== lv && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= lo && n <= lo + 5, 1'h1);
  endtask
  initial begin
    #(100 * 30000);
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rstn = 1;
    chk(gross_overcurrent_protect, 1'h1);
    chk({hot_alert_n, comparator_en}, 2'h3);
    rchk(8'h3D, 16'h0000);
    rchk(8'h49, 16'h1300);
    rchk(8'h3A, 16'h0000);
    system_power_monitor_enabled = 1;
    for (i = 0; i < 8; i++) begin
      ctrl = ($random(h.seed) & 'h3FFF) | ((i % 4) << 14);
      comparator_input = $random(h.seed);
      h.wr(8'h3D, ctrl[15:0]);
      chk(trickle_sel, ctrl[15:14]);
      chk(two_level_limit_en, ctrl[12]);
      chk({comparator_en, comparator_ref_2v}, {!ctrl[3], ctrl[4]});
      chk(comparator_output, !ctrl[3] & (comparator_input ^ ctrl[2]));
      chk(gross_overcurrent_protect, !ctrl[1]);
      chk(system_power_monitor_low_gain, ctrl[0]);
      rchk(8'h3D, ctrl[15:0]);
    end
    bias_ok = 0;
    h.wr(8'h3D, ~ctrl[15:0]);
    h.rd(8'h3D, d, v);
    chk(v, 1'h0);
    bias_ok = 1;
    rchk(8'h3D, ctrl[15:0]);
    foreach (vv[i]) begin
      x = (vv[i] >> 7) & 63;
      h.wr(8'h49, vv[i][15:0]);
      h.wr(8'h4A, vv[i][15:0]);
      e = x > 42 ? 42 : (x < 38 ? 38 : x);
      chk(otg_voltage_code, e);
      rchk(8'h49, e << 7);
      e = x > 32 ? 32 : x;
      rchk(8'h4A, e << 7);
      chk(otg_current_code, e);
    end
    for (i = 0; i < 6; i++) begin
      {config_strap_pin, trickle_active, conv_mode, charger_state, active_loop, reference_active} = $random(h.seed);
      h.wr(8'h3A, 16'hFFFF);
      rchk(8'h3A, {reference_active, active_loop, 3'h0, charger_state, conv_mode, trickle_active,
        config_strap_pin});
    end
    h.wr(8'h3D, 16'h2180);
    adapter_present = 1;
    meas(1, 1, TS);
    adapter_present = 0;
    meas(1, 0, 0);
    adapter_present = 1;
    meas(1, 1, TL);
    otg_request = 1;
    meas(0, 1, TS);
    otg_request = 0;
    h.wr(8'h3D, 16'h01A0);
    otg_request = 1;
    meas(0, 1, TL);
    meas(1, 0, 0);
    otg_request = 0;
    h.wr(8'h3D, 16'h0380);
    for (i = 0; i < 3; i++) begin
      {low_system_voltage_trip, battery_discharge_trip, adapter_current_trip} = 3'h1 << i;
      meas(2, 1, i == 2 ? 100 : 1000);
      rchk(8'h3A, {reference_active, active_loop, 3'h4 >> i, charger_state, conv_mode, trickle_active,
        config_strap_pin});
      {low_system_voltage_trip, battery_discharge_trip, adapter_current_trip} = 3'h0;
      meas(2, 0, 1000);
    end
    // Short insertion delay once the gate has dropped, then a mid-run reset must restore the first-insertion rule
    h.wr(8'h3D, 16'h0800);
    h.wr(8'h49, 16'h1500);
    adapter_present = 0;
    meas(1, 0, 0);
    adapter_present = 1;
    meas(1, 1, TS);
    rstn = 0;
    @(posedge clk);
    #1;
    rstn = 1;
    meas(1, 1, TS);
    rchk(8'h3D, 16'h0000);
    rchk(8'h49, 16'h1300);
    give_verdict;
  end
endmodule
bind ccsr_regs ccsr_checker u_chk (.clk, .rstn, .bias_ok, .wr_en, .rd_en, .cmd, .wr_data, .rd_valid,
  .otg_request, .otg_enable, .trickle_sel, .two_level_limit_en, .gross_overcurrent_protect,
  .system_power_monitor_low_gain, .otg_voltage_code, .otg_current_code);
